// *** core/lbc_bus_cmd.sv ***
// Local bus command, buffer control and queue status pin logic.
`timescale 1ns/1ps
module lbc_bus_cmd
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // Bus cycle requests
    input  wire logic                    req_valid,
    input  wire lbc_pkg::lbc_req_type    req,
    output logic                         req_ready,
    input  wire logic                    ready,
    output logic [lbc_pkg::LBC_DATA_W-1:0] rdata,
    output logic                         rdata_valid,
    // Queue events from the prefetch unit
    input  wire logic [1:0]              queue_event,
    // Chip select hits
    input  wire logic                    mem_cs_hit,
    input  wire logic                    per_cs_hit,
    input  wire logic                    per_cs_io,
    output logic                         mem_cs_n,
    output logic                         per_cs_n,
    // Address/data pins
    input  wire logic [lbc_pkg::LBC_DATA_W-1:0] ad_in,
    output logic [lbc_pkg::LBC_DATA_W-1:0] ad_out,
    output logic                         ad_oe_n,
    output logic [3:0]                   a_hi_out,
    // Read strobe pin
    input  wire logic                    rd_n_in,
    output logic                         rd_n_out,
    output logic                         rd_n_oe_n,
    output logic                         rd_pullup_en,
    // Command pins
    output lbc_pkg::lbc_cmd_type         cmd
);
    import lbc_pkg::*;

    lbc_tstate_type          st_q;
    lbc_tstate_type          st_d;
    logic                    phase_q;
    lbc_req_type             req_q;
    logic                    start_q;
    logic                    rdy_q;
    logic [2:0]              stat_q;
    logic                    ale_q;
    logic                    rd_act_q;
    logic                    wr_act_q;
    logic                    buf_en_n_q;
    logic                    dir_q;
    logic [LBC_DATA_W-1:0]   ad_q;
    logic                    oe_n_q;
    logic [3:0]              ahi_q;
    logic [LBC_DATA_W-1:0]   rdata_q;
    logic                    rvalid_q;
    logic                    strap_done;
    logic                    queue_mode;
    logic [1:0]              queue_state;

    // ==========================================================
    // Phase divider and decode
    // Each T-state is two mclk cycles; phase 1 is its second half.
    wire mid_en   = (phase_q == 1'b0);
    wire end_en   = (phase_q == 1'b1);
    wire pre_t1   = (st_q == LBC_TI) || (st_q == LBC_T4);
    wire accept   = req_valid && pre_t1 && mid_en && strap_done;
    wire is_read  = (req_q.status == LBC_ST_RD_IO) || (req_q.status == LBC_ST_RD_MEM)
                 || (req_q.status == LBC_ST_FETCH) || (req_q.status == LBC_ST_INTA);
    wire is_write = (req_q.status == LBC_ST_WR_IO) || (req_q.status == LBC_ST_WR_MEM);
    wire is_halt  = (req_q.status == LBC_ST_HALT);
    wire to_t1    = end_en && pre_t1 && start_q;
    wire to_t2    = end_en && (st_q == LBC_T1);
    wire to_t4    = end_en && ((st_q == LBC_T3) || (st_q == LBC_TW)) && rdy_q;
    wire space_io = (req_q.status[2] == 1'b0);
    wire bus_live = (st_q != LBC_TI);

    assign req_ready = pre_t1 && mid_en && strap_done;

    always_comb
    begin
        st_d = st_q;
        case (st_q)
            LBC_TI: st_d = start_q ? LBC_T1 : LBC_TI;
            LBC_T1: st_d = LBC_T2;
            LBC_T2: st_d = LBC_T3;
            LBC_T3: st_d = rdy_q ? LBC_T4 : LBC_TW;
            LBC_TW: st_d = rdy_q ? LBC_T4 : LBC_TW;
            LBC_T4: st_d = start_q ? LBC_T1 : LBC_TI;
            default: st_d = LBC_TI;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_q <= 1'b0;
            st_q    <= LBC_TI;
        end
        else
        begin
            phase_q <= ~phase_q;
            if (end_en)
                st_q <= st_d;
        end
    end

    // ==========================================================
    // Request, ready and status
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            req_q   <= '0;
            start_q <= 1'b0;
            rdy_q   <= 1'b0;
            stat_q  <= LBC_ST_RESET;
        end
        else
        begin
            if (accept)
                req_q <= req;
            if (accept)
                start_q <= 1'b1;
            else if (to_t1)
                start_q <= 1'b0;
            if (mid_en)
                rdy_q <= ready;
            if (accept)
                stat_q <= req.status;
            else if (mid_en && (st_q == LBC_T2) && is_halt)
                stat_q <= LBC_ST_PASSIVE;
            else if (mid_en && ((st_q == LBC_T3) || (st_q == LBC_TW)) && ready)
                stat_q <= LBC_ST_PASSIVE;
        end
    end

    // ==========================================================
    // Strobes, buffer control and address/data drive
    // Buffer enable is driven for every cycle except halt, and direction for every cycle, buffered target or not.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ale_q      <= 1'b0;
            rd_act_q   <= 1'b0;
            wr_act_q   <= 1'b0;
            buf_en_n_q <= 1'b1;
            dir_q      <= 1'b1;
            oe_n_q   <= 1'b1;
            ad_q     <= '0;
            ahi_q    <= '0;
        end
        else
        begin
            if (accept)
                ale_q <= 1'b1;
            else if (mid_en && (st_q == LBC_T1))
                ale_q <= 1'b0;
            if (to_t2)
                rd_act_q <= is_read;
            else if (to_t4)
                rd_act_q <= 1'b0;
            if (to_t2)
                wr_act_q <= is_write;
            else if (to_t4)
                wr_act_q <= 1'b0;
            if (to_t2 && !is_halt)
                buf_en_n_q <= 1'b0;
            else if (mid_en && (st_q == LBC_T4))
                buf_en_n_q <= 1'b1;
            if (to_t1)
                dir_q <= ~is_read;
            else if (mid_en && (st_q == LBC_T4))
                dir_q <= 1'b1;
            if (to_t1)
            begin
                oe_n_q <= 1'b0;
                ad_q   <= req_q.addr[LBC_DATA_W-1:0];
                ahi_q  <= req_q.addr[LBC_ADDR_W-1:LBC_DATA_W];
            end
            else if (to_t2)
            begin
                oe_n_q <= 1'b1;
                ahi_q  <= {req_q.dma, 3'h0};
            end
            else if (mid_en && (st_q == LBC_T2) && is_write)
            begin
                oe_n_q <= 1'b0;
                ad_q   <= req_q.wdata;
            end
            else if (end_en && (st_q == LBC_T4))
                oe_n_q <= 1'b1;
        end
    end

    // ==========================================================
    // Read data capture at the start of T4
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q  <= '0;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= to_t4 && is_read;
            if (to_t4 && is_read)
                rdata_q <= ad_in;
        end
    end

    // ==========================================================
    // Strap and queue state
    lbc_queue_status u_queue
    (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .fall_en     (mid_en),
        .rd_n_in     (rd_n_in),
        .queue_event (queue_event),
        .strap_done  (strap_done),
        .queue_mode  (queue_mode),
        .queue_state (queue_state)
    );

    // ==========================================================
    // Pin assembly
    // The strobe is gated by the float so the two never overlap on the bus.
    wire rd_on = rd_act_q && oe_n_q;
    wire wr_on = wr_act_q;

    assign rd_n_out     = ~rd_on;
    assign rd_n_oe_n    = ~strap_done || queue_mode;
    assign rd_pullup_en = 1'b1;
    assign cmd.wr_n     = queue_mode ? queue_state[1] : ~wr_on;
    assign cmd.ale      = queue_mode ? queue_state[0] : ale_q;
    assign cmd.data_buffer_enable_n = buf_en_n_q;
    assign cmd.data_direction       = dir_q;
    assign cmd.bus_cycle_status     = stat_q;
    assign ad_out       = ad_q;
    assign ad_oe_n      = oe_n_q;
    assign a_hi_out     = ahi_q;
    assign rdata        = rdata_q;
    assign rdata_valid  = rvalid_q;
    // Memory selects never answer I/O; peripheral selects follow the chosen space.
    assign mem_cs_n = ~(mem_cs_hit && bus_live && !space_io);
    assign per_cs_n = ~(per_cs_hit && bus_live && (space_io == per_cs_io));

    // ==========================================================
    // Assertions
    sequence s_read_t2;
        to_t2 && is_read && !queue_mode;
    endsequence

    property p_float_first;
        @(posedge mclk) disable iff (!rst_n)
        rd_act_q |-> ad_oe_n;
    endproperty
    a_float_first: assert property (p_float_first)
        else $error("read strobe active while address drive on");

    property p_buf_live;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == LBC_T3) && !is_halt |-> !cmd.data_buffer_enable_n;
    endproperty
    a_buf_live: assert property (p_buf_live)
        else $error("buffer enable off in T3");

    property p_buf_no_addr;
        @(posedge mclk) disable iff (!rst_n)
        !cmd.data_buffer_enable_n |-> (st_q != LBC_T1) && (st_q != LBC_TI);
    endproperty
    a_buf_no_addr: assert property (p_buf_no_addr)
        else $error("buffer enable on during address time");

    property p_dir_read;
        @(posedge mclk) disable iff (!rst_n)
        (rd_act_q || rvalid_q) |-> !cmd.data_direction;
    endproperty
    a_dir_read: assert property (p_dir_read)
        else $error("direction high during read");

    property p_rd_window;
        @(posedge mclk) disable iff (!rst_n)
        s_read_t2 |=> (!rd_n_out) [*4];
    endproperty
    a_rd_window: assert property (p_rd_window)
        else $error("read strobe not held through T2 and T3");

    property p_rd_release;
        @(posedge mclk) disable iff (!rst_n)
        $rose(rvalid_q) |-> rd_n_out && $past(!rd_n_out);
    endproperty
    a_rd_release: assert property (p_rd_release)
        else $error("read strobe not released at T4");

    property p_wr_data_late;
        @(posedge mclk) disable iff (!rst_n)
        $fell(cmd.wr_n) && !queue_mode |-> ad_oe_n ##1 !ad_oe_n;
    endproperty
    a_wr_data_late: assert property (p_wr_data_late)
        else $error("write data not one phase after strobe");

    property p_ale_pulse;
        @(posedge mclk) disable iff (!rst_n)
        accept && !queue_mode |=> cmd.ale [*2] ##1 !cmd.ale;
    endproperty
    a_ale_pulse: assert property (p_ale_pulse)
        else $error("address strobe width wrong");

    property p_idle_quiet;
        @(posedge mclk) disable iff (!rst_n)
        (st_q == LBC_TI) && !queue_mode |-> rd_n_out && cmd.wr_n
            && cmd.data_buffer_enable_n;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("strobes or buffer active while idle");

    property p_queue_pins;
        @(posedge mclk) disable iff (!rst_n)
        queue_mode && mid_en |=> {cmd.wr_n, cmd.ale} == $past(queue_event);
    endproperty
    a_queue_pins: assert property (p_queue_pins)
        else $error("queue pins do not follow queue event");

endmodule

// *** core/lbc_pkg.sv ***
// Package of constants and carrier types for the local bus command block.
package lbc_pkg;

    // ==========================================================
    // Bus cycle status codes
    localparam logic [2:0] LBC_ST_INTA    = 3'h0;
    localparam logic [2:0] LBC_ST_RD_IO   = 3'h1;
    localparam logic [2:0] LBC_ST_WR_IO   = 3'h2;
    localparam logic [2:0] LBC_ST_HALT    = 3'h3;
    localparam logic [2:0] LBC_ST_FETCH   = 3'h4;
    localparam logic [2:0] LBC_ST_RD_MEM  = 3'h5;
    localparam logic [2:0] LBC_ST_WR_MEM  = 3'h6;
    localparam logic [2:0] LBC_ST_PASSIVE = 3'h7;

    // ==========================================================
    // Queue state codes, high bit first
    localparam logic [1:0] LBC_QS_NOP     = 2'h0;
    localparam logic [1:0] LBC_QS_FIRST   = 2'h1;
    localparam logic [1:0] LBC_QS_REINIT  = 2'h2;
    localparam logic [1:0] LBC_QS_NEXT    = 2'h3;

    // ==========================================================
    // Widths and values after reset
    localparam int         LBC_ADDR_W     = 20;
    localparam int         LBC_DATA_W     = 16;
    localparam int         LBC_PHASES     = 2;
    localparam logic [1:0] LBC_QS_RESET   = 2'h0;
    localparam logic [2:0] LBC_ST_RESET   = 3'h7;

    // ==========================================================
    // T-states, one-hot
    typedef enum logic [5:0] {
        LBC_TI = 6'h01,
        LBC_T1 = 6'h02,
        LBC_T2 = 6'h04,
        LBC_T3 = 6'h08,
        LBC_TW = 6'h10,
        LBC_T4 = 6'h20
    } lbc_tstate_type;

    // ==========================================================
    // Bus cycle request from the execution side
    typedef struct packed {
        logic [2:0]            status;
        logic [LBC_ADDR_W-1:0] addr;
        logic [LBC_DATA_W-1:0] wdata;
        logic                  dma;
    } lbc_req_type;

    // Command and buffer-control pins
    typedef struct packed {
        logic       ale;
        logic       wr_n;
        logic       data_buffer_enable_n;
        logic       data_direction;
        logic [2:0] bus_cycle_status;
    } lbc_cmd_type;

endpackage

// *** core/lbc_queue_status.sv ***
// Reset strap capture and queue state register of the local bus command block.
`timescale 1ns/1ps
module lbc_queue_status
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Timing
    input  wire logic       fall_en,
    // Strap and queue events
    input  wire logic       rd_n_in,
    input  wire logic [1:0] queue_event,
    // Results
    output logic            strap_done,
    output logic            queue_mode,
    output logic [1:0]      queue_state
);
    import lbc_pkg::*;

    logic       done_q;
    logic       mode_q;
    logic [1:0] qs_q;

    // ==========================================================
    // Strap capture
    // The strap is taken at the first edge after release, never inside the reset itself.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            done_q <= 1'b0;
            mode_q <= 1'b0;
        end
        else if (!done_q)
        begin
            done_q <= 1'b1;
            mode_q <= ~rd_n_in;
        end
    end

    // ==========================================================
    // Queue state, moved on the falling processor edge in any T-state
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            qs_q <= LBC_QS_RESET;
        else if (fall_en)
            qs_q <= queue_event;
    end

    assign strap_done  = done_q;
    assign queue_mode  = mode_q;
    assign queue_state = qs_q;

endmodule

// *** testbench/lbc_bus_partner.sv ***
// Behavioural memory, peripheral and bus buffer model at the local bus pins.
`timescale 1ns/1ps
module lbc_bus_partner
    import lbc_pkg::*;
(
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Pins from the block
    input  wire lbc_pkg::lbc_cmd_type cmd,
    input  wire logic                 rd_n,
    input  wire logic                 mem_cs_n,
    input  wire logic                 per_cs_n,
    input  wire logic [15:0]          ad_out,
    input  wire logic                 ad_oe_n,
    // Behaviour control
    input  wire logic [3:0]           wait_cycles,
    // Answers to the block
    output logic [15:0]               ad_in,
    output logic                      ready
);
    logic [15:0] mem [0:255];
    logic [7:0]  addr_q;
    logic [2:0]  status_q;
    logic [15:0] last_q;
    logic        wr_q;
    logic [3:0]  cnt_q;
    logic        buf_oe_n;

    // ==========================================================
    // Buffers open only for a selected device, so reads never collide.
    assign buf_oe_n = cmd.data_buffer_enable_n | (mem_cs_n & per_cs_n);
    // A released bus shows a changing pattern, never the last word.
    assign ad_in = (!buf_oe_n && !rd_n) ? mem[addr_q] : ~last_q;
    assign ready = (cnt_q >= wait_cycles);

    always @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < 256; i++)
                mem[i] <= {8'hA5, 8'(i)};
            addr_q   <= 8'h00;
            status_q <= 3'h7;
            last_q   <= 16'h0000;
            wr_q     <= 1'b1;
            cnt_q    <= 4'h0;
        end
        else
        begin
            last_q <= ad_in;
            wr_q   <= cmd.wr_n;
            if (cmd.ale)
                status_q <= cmd.bus_cycle_status;
            if (cmd.ale && !ad_oe_n)
                addr_q <= ad_out[7:0];
            if (!wr_q && cmd.wr_n && !ad_oe_n)
                mem[addr_q] <= ad_out;
            if (rd_n && cmd.wr_n)
                cnt_q <= 4'h0;
            else if (cnt_q != 4'hF)
                cnt_q <= cnt_q + 4'h1;
        end
    end
endmodule

// *** testbench/lbc_bus_cmd_tb.sv ***
// Self-checking testbench of the local bus command block.
`timescale 1ns/1ps
module lbc_bus_cmd_tb;
    import lbc_pkg::*;
    logic        mclk, rst_n, req_valid, req_ready, ready, rdata_valid;
    lbc_req_type req;
    lbc_cmd_type cmd;
    logic [15:0] rdata, ad_in, ad_out;
    logic [3:0]  a_hi_out, wait_cycles;
    logic [1:0]  queue_event;
    logic        mem_cs_hit, per_cs_hit, per_cs_io, mem_cs_n, per_cs_n;
    logic        ad_oe_n, rd_n_in, rd_n_out, rd_n_oe_n, rd_pullup_en, strap_low;
    int          err_total, cmp_count, cyc;
    lbc_cmd_type cmd_t [0:23];
    logic        rd_t [0:23], oe_t [0:23], rv_t [0:23];
    logic [1:0]  cs_t [0:23];
    logic [15:0] ad_t [0:23], dat_t [0:23];
    logic [3:0]  ahi_t [0:23];

    // ==========================================================
    // Read pin: weak pull-up unless the bench grounds it as a strap.
    assign rd_n_in = !rd_n_oe_n ? rd_n_out :
                     (strap_low ? 1'b0 : (rd_pullup_en ? 1'b1 : 1'bz));

    lbc_bus_cmd i_lbc_bus_cmd (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .ready(ready), .rdata(rdata),
        .rdata_valid(rdata_valid), .queue_event(queue_event), .mem_cs_hit(mem_cs_hit),
        .per_cs_hit(per_cs_hit), .per_cs_io(per_cs_io), .mem_cs_n(mem_cs_n),
        .per_cs_n(per_cs_n), .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .a_hi_out(a_hi_out), .rd_n_in(rd_n_in), .rd_n_out(rd_n_out),
        .rd_n_oe_n(rd_n_oe_n), .rd_pullup_en(rd_pullup_en), .cmd(cmd));

    lbc_bus_partner i_lbc_bus_partner (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
        .rd_n(rd_n_in), .mem_cs_n(mem_cs_n), .per_cs_n(per_cs_n), .ad_out(ad_out),
        .ad_oe_n(ad_oe_n), .wait_cycles(wait_cycles), .ad_in(ad_in), .ready(ready));

    always #4 mclk = ~mclk;

    // ==========================================================
    // The whole run needs under a thousand cycles.
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            err_total++;
            complete_run();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic do_reset(input logic strap);
        rst_n     = 1'b0;
        strap_low = strap;
        repeat (5) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #1;
    endtask

    // Issue one request and record n cycles, index 1 right after acceptance.
    task automatic issue(input logic [2:0] st, input logic [15:0] a,
                         input logic [15:0] wd, input int n);
        int k;
        k         = 0;
        req       = '{status: st, addr: {4'hB, a}, wdata: wd, dma: 1'b1};
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && k < 40)
        begin
            @(posedge mclk);
            #1;
            k++;
        end
        chk("accept", 32'(req_ready), 32'h1);
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        for (k = 1; k <= n; k++)
        begin
            cmd_t[k] = cmd;
            rd_t[k]  = rd_n_in;
            oe_t[k]  = ad_oe_n;
            ad_t[k]  = ad_out;
            rv_t[k]  = rdata_valid;
            dat_t[k] = rdata;
            cs_t[k]  = {mem_cs_n, per_cs_n};
            ahi_t[k] = a_hi_out;
            if (k < n)
            begin
                @(posedge mclk);
                #1;
            end
        end
    endtask

    task automatic t_idle;
        chk("idle pins", 32'({cmd.ale, cmd.wr_n, cmd.data_buffer_enable_n,
            cmd.bus_cycle_status, rd_n_in}), 32'h3F);
        chk("pull-up", 32'({rd_pullup_en, rd_n_oe_n}), 32'h2);
    endtask

    task automatic t_read(input logic [2:0] st, input logic [15:0] a, input logic [15:0] exp);
        issue(st, a, 16'h0000, 12);
        chk("rd status", 32'(cmd_t[1].bus_cycle_status), 32'(st));
        chk("rd ale", 32'({cmd_t[1].ale, cmd_t[3].ale}), 32'h2);
        chk("rd addr", 32'({oe_t[2], ad_t[2]}), 32'(a));
        chk("rd t2", 32'({oe_t[4], rd_t[3], rd_t[4], cmd_t[4].data_buffer_enable_n,
            cmd_t[4].data_direction}), 32'h18);
        chk("rd cs", 32'(cs_t[4]), 32'({!st[2], st[2]}));
        chk("rd high", 32'({ahi_t[2], ahi_t[4]}), 32'hB8);
        chk("rd t4", 32'({rd_t[7], rd_t[8], rv_t[8], dat_t[8]}),
            32'({3'b011, exp}));
        chk("rd end", 32'({cmd_t[9].data_buffer_enable_n, cmd_t[9].data_direction,
            cmd_t[11].data_buffer_enable_n, rd_t[11]}), 32'hF);
    endtask

    task automatic t_write(input logic [2:0] st, input logic [15:0] a, input logic [15:0] wd);
        issue(st, a, wd, 12);
        chk("wr status", 32'(cmd_t[1].bus_cycle_status), 32'(st));
        chk("wr t2", 32'({oe_t[4], cmd_t[3].wr_n, cmd_t[4].wr_n,
            cmd_t[4].data_buffer_enable_n, cmd_t[4].data_direction}), 32'h19);
        chk("wr data", 32'({oe_t[5], ad_t[5]}), 32'(wd));
        chk("wr t4", 32'({cmd_t[7].wr_n, cmd_t[8].wr_n, rd_t[4],
            cmd_t[2].data_direction}), 32'h7);
    endtask

    task automatic t_wait;
        int k, len, v;
        len         = 0;
        v           = 0;
        wait_cycles = 4'h5;
        issue(LBC_ST_RD_MEM, 16'h0144, 16'h0000, 22);
        for (k = 1; k <= 22; k++)
        begin
            len = len + ((rd_t[k] === 1'b0) ? 1 : 0);
            if (rv_t[k] === 1'b1)
                v = k;
        end
        chk("wait data", 32'(dat_t[v]), 32'hA544);
        chk("wait len", 32'({len > 4, len[0]}), 32'h2);
        wait_cycles = 4'h0;
    endtask

    task automatic t_b2b;
        issue(LBC_ST_RD_MEM, 16'h0155, 16'h0000, 8);
        chk("b2b rdata", 32'({rv_t[8], dat_t[8]}), 32'h1A555);
        chk("b2b ready", 32'(req_ready), 32'h1);
        t_write(LBC_ST_WR_MEM, 16'h0166, 16'h3CC3);
        chk("b2b hold", 32'({rv_t[1], dat_t[1]}), 32'h0A555);
        chk("b2b buffer", 32'({cmd_t[2].data_buffer_enable_n, oe_t[2]}), 32'h2);
    endtask

    task automatic t_halt;
        issue(LBC_ST_HALT, 16'h0300, 16'h0000, 10);
        chk("halt status", 32'({cmd_t[1].bus_cycle_status, cmd_t[4].bus_cycle_status,
            cmd_t[5].bus_cycle_status}), 32'h0DF);
        chk("halt quiet", 32'({rd_t[4], cmd_t[4].wr_n, cmd_t[4].data_buffer_enable_n}),
            32'h7);
    endtask

    task automatic t_queue;
        logic [1:0] code;
        logic       hit;
        int         i, k, first;
        first = -1;
        do_reset(1'b1);
        for (i = 1; i <= 4; i++)
        begin
            code        = 2'(i);
            queue_event = code;
            hit         = 1'b0;
            for (k = 0; k < 4; k++)
            begin
                @(posedge mclk);
                #1;
                if ({cmd.wr_n, cmd.ale} === code && !hit)
                begin
                    hit = 1'b1;
                    if (first < 0)
                        first = cyc % 2;
                    else
                        chk("queue edge", 32'(cyc % 2), 32'(first));
                end
            end
            chk("queue pins", 32'({cmd.wr_n, cmd.ale}), 32'(code));
            chk("rd released", 32'(rd_n_oe_n), 32'h1);
        end
        queue_event = 2'h0;
    endtask

    initial
    begin
        mclk        = 1'b0;
        rst_n       = 1'b0;
        req_valid   = 1'b0;
        req         = '0;
        queue_event = 2'h0;
        mem_cs_hit  = 1'b1;
        per_cs_hit  = 1'b1;
        per_cs_io   = 1'b1;
        wait_cycles = 4'h0;
        strap_low   = 1'b0;
        err_total   = 0;
        cmp_count   = 0;
        cyc         = 0;
        do_reset(1'b0);
        t_idle();
        t_read(LBC_ST_RD_IO, 16'h0110, 16'hA510);
        t_read(LBC_ST_RD_MEM, 16'h0111, 16'hA511);
        t_read(LBC_ST_FETCH, 16'h0112, 16'hA512);
        t_read(LBC_ST_INTA, 16'h0113, 16'hA513);
        t_halt();
        t_write(LBC_ST_WR_IO, 16'h0220, 16'hC33C);
        t_write(LBC_ST_WR_MEM, 16'h0231, 16'h9E61);
        t_read(LBC_ST_RD_MEM, 16'h0231, 16'h9E61);
        t_wait();
        t_b2b();
        t_queue();
        complete_run();
    end
endmodule
